// ==== logic/usb_sysctl_defines.vh ====
// Constants for the USB system control and interrupt source block
`ifndef USB_SYSCTL_DEFINES_VH
`define USB_SYSCTL_DEFINES_VH

// ==========================================================
// Sizes
`define PIPE_COUNT 10
`define PIPE_MSB 9

// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define ATTACH_TIME_NS 2500
`define ATTACH_CYCLES ((`ATTACH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ATTACH_CNT_W 7
`define RETRY_LIMIT 2'h3

// ==========================================================
// Line states (J = 2'h1 full speed view)
`define LINE_SE0 2'h0
`define LINE_J 2'h1
`define LINE_K 2'h2

// ==========================================================
// Status enable bit positions
`define EN_VBUS 0
`define EN_RESUME 1
`define EN_FRAME 2
`define EN_DEVST 3
`define EN_CTRL 4
`define EN_EMPTY 5
`define EN_NOT_READY_IRQ 6
`define EN_BUFFER_READY_IRQ 7
`define EN_OVERCURRENT_IRQ 8
`define EN_LINE 9
`define EN_DETACH 10
`define EN_ATTACH 11
`define EN_FRAME_END_ERROR_IRQ 12
`define EN_SETUPOK 13
`define EN_SETUPERR 14
`define EN_PORTABLE 15
`define IRQ_COUNT 16

// ==========================================================
// Reset values
`define DEV_STATE_RESET 3'h0
`define CTRL_STAGE_RESET 3'h0

`endif

// ==== logic/usb_sysctl_irq.v ====
// System control, resistor control and interrupt sources of a host/function USB block
`timescale 1ns/10ps
`include "usb_sysctl_defines.vh"

module usb_sysctl_irq (
	// Clock and reset
	input wire CLK,
	input wire RST,
	// System configuration
	input wire CLOCK_SUPPLY_ENABLE,
	input wire MODULE_ENABLE,
	input wire ROLE_SELECT,
	input wire DPLUS_PULLUP_ENABLE,
	input wire DMINUS_PULLUP_ENABLE,
	input wire LINE_PULLDOWN_ENABLE,
	output reg USB_RUNNING,
	// Resistor controls to the pads
	output reg DPLUS_PULLUP,
	output reg DMINUS_PULLUP,
	output reg DPLUS_PULLDOWN,
	output reg DMINUS_PULLDOWN,
	// Pins from outside
	input wire VBUS_SENSE_PIN,
	input wire OVERCURRENT_IN_A,
	input wire OVERCURRENT_IN_B,
	input wire [1:0] LINE_STATE_IN,
	// Events from the protocol engine
	input wire SUSPENDED,
	input wire SOF_NEW_FRAME,
	input wire BUS_RESET_EV,
	input wire SUSPEND_EV,
	input wire SET_ADDRESS_EV,
	input wire SET_CONFIG_EV,
	input wire [2:0] NEW_DEV_STATE,
	input wire CTRL_STAGE_EV,
	input wire [2:0] NEW_CTRL_STAGE,
	input wire [`PIPE_MSB:0] PIPE_SENT_EMPTY,
	input wire [`PIPE_MSB:0] PIPE_OVERSIZE,
	input wire [`PIPE_MSB:0] PIPE_STALL_RX,
	input wire [`PIPE_MSB:0] PIPE_TXN_FAIL,
	input wire [`PIPE_MSB:0] PIPE_TXN_OK,
	input wire [`PIPE_MSB:0] PIPE_ISO_ERR,
	input wire [`PIPE_MSB:0] PIPE_NAK_BUF,
	input wire [`PIPE_MSB:0] PIPE_ACCESSIBLE,
	input wire DETACH_EV,
	input wire FRAME_END_ERR_EV,
	input wire PORTABLE_DETECT_EV,
	input wire SETUP_ACK_EV,
	input wire SETUP_FAIL_EV,
	// Transfer helper requests
	input wire XFER_REQ_0_IN,
	input wire XFER_REQ_1_IN,
	// Interrupt enables and clears
	input wire [`IRQ_COUNT-1:0] IRQ_ENABLE,
	input wire [`IRQ_COUNT-1:0] IRQ_CLEAR,
	input wire [`PIPE_MSB:0] PIPE_EMPTY_ENABLE,
	input wire [`PIPE_MSB:0] PIPE_NOT_READY_IRQ_ENABLE,
	input wire [`PIPE_MSB:0] PIPE_READY_ENABLE,
	input wire [`PIPE_MSB:0] PIPE_EMPTY_CLEAR,
	input wire [`PIPE_MSB:0] PIPE_NOT_READY_IRQ_CLEAR,
	input wire [`PIPE_MSB:0] PIPE_READY_CLEAR,
	// Status
	output wire [`IRQ_COUNT-1:0] IRQ_STATUS,
	output reg VBUS_LEVEL_FLAG,
	output reg [2:0] DEV_STATE_FIELD,
	output reg [2:0] CTRL_STAGE_FIELD,
	output reg [1:0] LINE_STATE_FIELD,
	output wire [`PIPE_MSB:0] PIPE_EMPTY_FLAG,
	output wire [`PIPE_MSB:0] PIPE_NOTREADY_FLAG,
	output wire [`PIPE_MSB:0] PIPE_READY_FLAG,
	// To the CPU interrupt controller
	output reg FIFO_XFER_REQ_0,
	output reg FIFO_XFER_REQ_1,
	output reg COMBINED_IRQ_OUT,
	output reg WAKEUP_IRQ_OUT
);

	// ==========================================================
	// Pin synchronisers
	reg [4:0] pin_meta_q;
	reg [4:0] pin_sync_q;
	reg [4:0] pin_prev_q;
	reg clk_seen_q;
	reg [`IRQ_COUNT-1:0] irq_q;
	reg [`IRQ_COUNT-1:0] ev;
	reg [`ATTACH_CNT_W-1:0] attach_cnt_q;
	reg [1:0] setup_fail_q;
	reg [1:0] pipe_fail_q [0:`PIPE_MSB];
	reg [`PIPE_MSB:0] empty_q;
	reg [`PIPE_MSB:0] not_ready_irq_q;
	reg [`PIPE_MSB:0] ready_q;
	reg [`PIPE_MSB:0] acc_prev_q;
	wire vbus_s;
	wire oca_s;
	wire ocb_s;
	wire [1:0] line_s;
	wire [1:0] line_prev;
	wire host;

	assign vbus_s = pin_sync_q[0];
	assign oca_s = pin_sync_q[1];
	assign ocb_s = pin_sync_q[2];
	assign line_s = pin_sync_q[4:3];
	assign line_prev = pin_prev_q[4:3];
	assign host = ROLE_SELECT;

	always @(posedge CLK) begin
		if (RST) begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
			pin_prev_q <= 5'h00;
		end else begin
			pin_meta_q <= {LINE_STATE_IN, OVERCURRENT_IN_B, OVERCURRENT_IN_A, VBUS_SENSE_PIN};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// ==========================================================
	// Enable sequence
	always @(posedge CLK) begin
		if (RST) begin
			clk_seen_q <= 1'b0;
			USB_RUNNING <= 1'b0;
		end else begin
			clk_seen_q <= CLOCK_SUPPLY_ENABLE;
			USB_RUNNING <= MODULE_ENABLE & clk_seen_q & CLOCK_SUPPLY_ENABLE;
		end
	end

	// ==========================================================
	// Data line resistors
	// Role changes are software's duty while resistors are off.
	always @(posedge CLK) begin
		if (RST) begin
			DPLUS_PULLUP <= 1'b0;
			DMINUS_PULLUP <= 1'b0;
			DPLUS_PULLDOWN <= 1'b0;
			DMINUS_PULLDOWN <= 1'b0;
		end else begin
			// Full or low speed pull-up, cleared bit drops it
			DPLUS_PULLUP <= ~LINE_PULLDOWN_ENABLE & DPLUS_PULLUP_ENABLE & ~DMINUS_PULLUP_ENABLE;
			DMINUS_PULLUP <= ~LINE_PULLDOWN_ENABLE & ~DPLUS_PULLUP_ENABLE & DMINUS_PULLUP_ENABLE;
			// Host pull-downs; all zero leaves open
			DPLUS_PULLDOWN <= LINE_PULLDOWN_ENABLE & ~DPLUS_PULLUP_ENABLE & ~DMINUS_PULLUP_ENABLE;
			DMINUS_PULLDOWN <= LINE_PULLDOWN_ENABLE & ~DPLUS_PULLUP_ENABLE & ~DMINUS_PULLUP_ENABLE;
		end
	end

	// ==========================================================
	// Per pipe flags
	genvar p;
	generate
		for (p = 0; p < `PIPE_COUNT; p = p + 1) begin : g_pipe
			wire fail_third;
			assign fail_third = PIPE_TXN_FAIL[p] && (pipe_fail_q[p] == `RETRY_LIMIT - 2'h1);
			always @(posedge CLK) begin
				if (RST) begin
					pipe_fail_q[p] <= 2'h0;
					empty_q[p] <= 1'b0;
					not_ready_irq_q[p] <= 1'b0;
					ready_q[p] <= 1'b0;
					acc_prev_q[p] <= 1'b0;
				end else begin
					acc_prev_q[p] <= PIPE_ACCESSIBLE[p];
					if (PIPE_TXN_OK[p] || PIPE_STALL_RX[p] || fail_third)
						pipe_fail_q[p] <= 2'h0;
					else if (PIPE_TXN_FAIL[p])
						pipe_fail_q[p] <= pipe_fail_q[p] + 2'h1;
					// Empty or oversize; set wins over clear
					if (PIPE_SENT_EMPTY[p] || PIPE_OVERSIZE[p])
						empty_q[p] <= 1'b1;
					else if (PIPE_EMPTY_CLEAR[p])
						empty_q[p] <= 1'b0;
					if ((host && (PIPE_STALL_RX[p] || fail_third || PIPE_ISO_ERR[p])) ||
						(!host && (PIPE_NAK_BUF[p] || PIPE_ISO_ERR[p])))
						not_ready_irq_q[p] <= 1'b1;
					else if (PIPE_NOT_READY_IRQ_CLEAR[p])
						not_ready_irq_q[p] <= 1'b0;
					if (PIPE_ACCESSIBLE[p] && !acc_prev_q[p])
						ready_q[p] <= 1'b1;
					else if (PIPE_READY_CLEAR[p])
						ready_q[p] <= 1'b0;
				end
			end
		end
	endgenerate

	assign PIPE_EMPTY_FLAG = empty_q;
	assign PIPE_NOTREADY_FLAG = not_ready_irq_q;
	assign PIPE_READY_FLAG = ready_q;

	// ==========================================================
	// Attach timing
	// Counter saturates so attach fires once per stable period
	localparam integer ATTACH_N = `ATTACH_CYCLES;
	localparam [`ATTACH_CNT_W-1:0] ATTACH_MAX = ATTACH_N[`ATTACH_CNT_W-1:0];
	localparam [`ATTACH_CNT_W-1:0] ATTACH_LAST = ATTACH_MAX - {{(`ATTACH_CNT_W-1){1'b0}}, 1'b1};
	wire attach_at_max;
	wire attach_at_last;
	assign attach_at_max = (attach_cnt_q == ATTACH_MAX);
	assign attach_at_last = (attach_cnt_q == ATTACH_LAST);

	// ==========================================================
	// Event detection
	wire attach_hold;
	wire setup_err_ev;
	assign attach_hold = (line_s == `LINE_J) || (line_s == `LINE_K);
	assign setup_err_ev = SETUP_FAIL_EV && (setup_fail_q == `RETRY_LIMIT - 2'h1);

	always @(posedge CLK) begin
		if (RST) begin
			attach_cnt_q <= {`ATTACH_CNT_W{1'b0}};
			setup_fail_q <= 2'h0;
		end else begin
			// Count stable J or K time
			if (!host || !attach_hold || line_s != line_prev)
				attach_cnt_q <= {`ATTACH_CNT_W{1'b0}};
			else if (!attach_at_max)
				attach_cnt_q <= attach_cnt_q + {{(`ATTACH_CNT_W-1){1'b0}}, 1'b1};
			if (SETUP_ACK_EV || setup_err_ev)
				setup_fail_q <= 2'h0;
			else if (SETUP_FAIL_EV)
				setup_fail_q <= setup_fail_q + 2'h1;
		end
	end

	always @* begin
		ev = {`IRQ_COUNT{1'b0}};
		ev[`EN_VBUS] = vbus_s ^ pin_prev_q[0];
		ev[`EN_RESUME] = !host && SUSPENDED && line_prev == `LINE_J &&
			(line_s == `LINE_K || line_s == `LINE_SE0);
		ev[`EN_FRAME] = SOF_NEW_FRAME;
		ev[`EN_DEVST] = !host && (BUS_RESET_EV || SUSPEND_EV || SET_ADDRESS_EV || SET_CONFIG_EV);
		ev[`EN_CTRL] = !host && CTRL_STAGE_EV;
		ev[`EN_EMPTY] = |(empty_q & PIPE_EMPTY_ENABLE);
		ev[`EN_NOT_READY_IRQ] = |(not_ready_irq_q & PIPE_NOT_READY_IRQ_ENABLE);
		ev[`EN_BUFFER_READY_IRQ] = |(ready_q & PIPE_READY_ENABLE);
		ev[`EN_OVERCURRENT_IRQ] = host && ((oca_s ^ pin_prev_q[1]) || (ocb_s ^ pin_prev_q[2]));
		ev[`EN_LINE] = line_s != line_prev;
		ev[`EN_DETACH] = host && DETACH_EV;
		ev[`EN_ATTACH] = host && attach_hold && line_s == line_prev && attach_at_last;
		ev[`EN_FRAME_END_ERROR_IRQ] = host && FRAME_END_ERR_EV;
		ev[`EN_SETUPOK] = host && SETUP_ACK_EV;
		ev[`EN_SETUPERR] = host && setup_err_ev;
		ev[`EN_PORTABLE] = host && PORTABLE_DETECT_EV;
	end

	// ==========================================================
	// Sticky status per source
	genvar s;
	generate
		for (s = 0; s < `IRQ_COUNT; s = s + 1) begin : g_irq
			always @(posedge CLK) begin
				if (RST)
					irq_q[s] <= 1'b0;
				else if (ev[s])
					irq_q[s] <= 1'b1;
				else if (IRQ_CLEAR[s])
					irq_q[s] <= 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// Status fields
	always @(posedge CLK) begin
		if (RST) begin
			VBUS_LEVEL_FLAG <= 1'b0;
			DEV_STATE_FIELD <= `DEV_STATE_RESET;
			CTRL_STAGE_FIELD <= `CTRL_STAGE_RESET;
			LINE_STATE_FIELD <= 2'h0;
		end else begin
			VBUS_LEVEL_FLAG <= vbus_s;
			LINE_STATE_FIELD <= line_s;
			if (ev[`EN_DEVST])
				DEV_STATE_FIELD <= NEW_DEV_STATE;
			if (ev[`EN_CTRL])
				CTRL_STAGE_FIELD <= NEW_CTRL_STAGE;
		end
	end

	assign IRQ_STATUS = irq_q;

	// ==========================================================
	// Outputs to the interrupt controller
	localparam [`IRQ_COUNT-1:0] WAKE_MASK = (16'h0001 << `EN_VBUS) | (16'h0001 << `EN_RESUME) |
		(16'h0001 << `EN_OVERCURRENT_IRQ) | (16'h0001 << `EN_LINE) | (16'h0001 << `EN_PORTABLE);

	always @(posedge CLK) begin
		if (RST) begin
			FIFO_XFER_REQ_0 <= 1'b0;
			FIFO_XFER_REQ_1 <= 1'b0;
			COMBINED_IRQ_OUT <= 1'b0;
			WAKEUP_IRQ_OUT <= 1'b0;
		end else begin
			FIFO_XFER_REQ_0 <= XFER_REQ_0_IN;
			FIFO_XFER_REQ_1 <= XFER_REQ_1_IN;
			COMBINED_IRQ_OUT <= |(irq_q & IRQ_ENABLE);
			WAKEUP_IRQ_OUT <= |(irq_q & IRQ_ENABLE & WAKE_MASK);
		end
	end

endmodule

// ==== tb/usb_cable_model.sv ====
// Cable partner: a full-speed peer that supplies VBUS and shows line state
`timescale 1ns/10ps
module usb_cable_model (
	// Clock and commands
	input wire clk,
	input wire plug,
	input wire resume_k,
	// Resistor controls of the block
	input wire [3:0] pads,
	// Cable lines
	output reg vbus = 1'h0,
	output reg [1:0] line = 2'h0
);
	// Unplugged lines sit at SE0 through the pull-downs
	always @(posedge clk) begin
		vbus <= #1 plug;
		if (!plug) line <= #1 2'h0;
		else if (resume_k) line <= #1 2'h2;
		else if (pads[3] || pads[1]) line <= #1 2'h1;
		else if (pads[2]) line <= #1 2'h2;
		else line <= #1 2'h0;
	end
endmodule

// ==== tb/usb_sysctl_irq_chk.sv ====
// Port assertions for the USB system control block
`timescale 1ns/10ps
module usb_sysctl_irq_chk (
	// Clock, reset and configuration
	input wire CLK, RST, CLOCK_SUPPLY_ENABLE, MODULE_ENABLE, ROLE_SELECT, VBUS_SENSE_PIN, BUS_RESET_EV,
	input wire DPLUS_PULLUP_ENABLE, DMINUS_PULLUP_ENABLE, LINE_PULLDOWN_ENABLE,
	input wire [1:0] LINE_STATE_IN,
	input wire [2:0] NEW_DEV_STATE, DEV_STATE_FIELD,
	input wire [15:0] IRQ_ENABLE, IRQ_STATUS,
	// Outputs
	input wire USB_RUNNING, DPLUS_PULLUP, DMINUS_PULLUP, DPLUS_PULLDOWN, DMINUS_PULLDOWN,
	input wire COMBINED_IRQ_OUT, WAKEUP_IRQ_OUT
);
	wire [2:0] cfg = {LINE_PULLDOWN_ENABLE, DPLUS_PULLUP_ENABLE, DMINUS_PULLUP_ENABLE};
	wire [3:0] pads = {DPLUS_PULLUP, DMINUS_PULLUP, DPLUS_PULLDOWN, DMINUS_PULLDOWN};
	reg [7:0] run_q;
	reg [1:0] line_q;
	// Raw line stability; saturates so a long idle never wraps
	always @(posedge CLK) begin
		line_q <= LINE_STATE_IN;
		if (LINE_STATE_IN != line_q || LINE_STATE_IN == 2'h0) run_q <= 8'h0;
		else if (run_q != 8'hff) run_q <= run_q + 8'h1;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ==========
	// Properties
	sequence s_dev; BUS_RESET_EV && !ROLE_SELECT; endsequence
	sequence s_dev_seen; IRQ_STATUS[3] && DEV_STATE_FIELD == $past(NEW_DEV_STATE); endsequence
	property p_run; $rose(USB_RUNNING) |-> $past(CLOCK_SUPPLY_ENABLE, 2) && $past(MODULE_ENABLE); endproperty
	a_run: assert property (p_run) else $error("run without clock first");
	property p_fs; cfg == 3'h2 |=> pads == 4'h8; endproperty
	a_fs: assert property (p_fs) else $error("full speed pads wrong");
	property p_ls; cfg == 3'h1 |=> pads == 4'h4; endproperty
	a_ls: assert property (p_ls) else $error("low speed pads wrong");
	property p_host; cfg == 3'h4 |=> pads == 4'h3; endproperty
	a_host: assert property (p_host) else $error("host pads wrong");
	property p_open; cfg == 3'h0 |=> pads == 4'h0; endproperty
	a_open: assert property (p_open) else $error("lines not open");
	property p_comb; !$past(RST) |-> COMBINED_IRQ_OUT == $past(|(IRQ_STATUS & IRQ_ENABLE)); endproperty
	a_comb: assert property (p_comb) else $error("combined irq wrong");
	property p_wake; !$past(RST) |-> WAKEUP_IRQ_OUT == $past(|(IRQ_STATUS & IRQ_ENABLE & 16'h8303)); endproperty
	a_wake: assert property (p_wake) else $error("wakeup irq wrong");
	property p_vbus; $changed(VBUS_SENSE_PIN) |-> ##[1:4] IRQ_STATUS[0]; endproperty
	a_vbus: assert property (p_vbus) else $error("vbus edge missed");
	property p_attach; $rose(IRQ_STATUS[11]) |-> ROLE_SELECT && run_q >= 8'h78; endproperty
	a_attach: assert property (p_attach) else $error("attach too early");
	property p_dev; s_dev |=> s_dev_seen; endproperty
	a_dev: assert property (p_dev) else $error("device state not recorded");
endmodule
bind usb_sysctl_irq usb_sysctl_irq_chk chk (.*);

// ==== tb/usb_sysctl_irq_test.sv ====
// Self-checking bench for the USB system control block
`timescale 1ns/10ps
module usb_sysctl_irq_test;
	logic CLK = '0, RST = '1, plug = '0, resume_k = '0, CLOCK_SUPPLY_ENABLE = '0, MODULE_ENABLE = '0;
	logic ROLE_SELECT = '0, DPLUS_PULLUP_ENABLE = '0, DMINUS_PULLUP_ENABLE = '0, LINE_PULLDOWN_ENABLE = '0;
	logic SUSPENDED = '0, OVERCURRENT_IN_A = '0, OVERCURRENT_IN_B = '0, SOF_NEW_FRAME = '0, BUS_RESET_EV = '0;
	logic SUSPEND_EV = '0, SET_ADDRESS_EV = '0, SET_CONFIG_EV = '0, CTRL_STAGE_EV = '0, DETACH_EV = '0;
	logic FRAME_END_ERR_EV = '0, PORTABLE_DETECT_EV = '0, SETUP_ACK_EV = '0, SETUP_FAIL_EV = '0;
	logic XFER_REQ_0_IN = '0, XFER_REQ_1_IN = '0;
	logic [2:0] NEW_DEV_STATE = '0, NEW_CTRL_STAGE = '0;
	logic [15:0] IRQ_ENABLE = '0, IRQ_CLEAR = '0;
	logic [9:0] PIPE_SENT_EMPTY = '0, PIPE_OVERSIZE = '0, PIPE_STALL_RX = '0, PIPE_TXN_FAIL = '0;
	logic [9:0] PIPE_TXN_OK = '0, PIPE_ISO_ERR = '0, PIPE_NAK_BUF = '0, PIPE_ACCESSIBLE = '0;
	logic [9:0] PIPE_EMPTY_ENABLE = '1, PIPE_NOT_READY_IRQ_ENABLE = '1, PIPE_READY_ENABLE = '1;
	logic [9:0] PIPE_EMPTY_CLEAR = '0, PIPE_NOT_READY_IRQ_CLEAR = '0, PIPE_READY_CLEAR = '0;
	wire USB_RUNNING, DPLUS_PULLUP, DMINUS_PULLUP, DPLUS_PULLDOWN, DMINUS_PULLDOWN, VBUS_SENSE_PIN;
	wire VBUS_LEVEL_FLAG, FIFO_XFER_REQ_0, FIFO_XFER_REQ_1, COMBINED_IRQ_OUT, WAKEUP_IRQ_OUT;
	wire [1:0] LINE_STATE_IN, LINE_STATE_FIELD;
	wire [2:0] DEV_STATE_FIELD, CTRL_STAGE_FIELD;
	wire [15:0] IRQ_STATUS;
	wire [9:0] PIPE_EMPTY_FLAG, PIPE_NOTREADY_FLAG, PIPE_READY_FLAG;
	wire [3:0] pads = {DPLUS_PULLUP, DMINUS_PULLUP, DPLUS_PULLDOWN, DMINUS_PULLDOWN};
	int err_total = 0;
	int n_checks = 0;
	usb_sysctl_irq DUT (.*);
	usb_cable_model cable (.clk(CLK), .plug(plug), .resume_k(resume_k), .pads(pads), .vbus(VBUS_SENSE_PIN),
		.line(LINE_STATE_IN));
	always #10 CLK = ~CLK;
	// ==========
	// Helpers
	task step(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ==========
	// Scenarios
	task t_run;
		MODULE_ENABLE = '1;
		XFER_REQ_0_IN = '1;
		XFER_REQ_1_IN = '1;
		step(3);
		chk("run", 16'h0, USB_RUNNING);
		chk("xfer", 16'h1, FIFO_XFER_REQ_0);
		chk("xfer1", 16'h1, FIFO_XFER_REQ_1);
		MODULE_ENABLE = '0;
		CLOCK_SUPPLY_ENABLE = '1;
		step(2);
		MODULE_ENABLE = '1;
		step(2);
		chk("run", 16'h1, USB_RUNNING);
	endtask
	task t_pads;
		logic [3:0] cfg [5] = '{4'h2, 4'h1, 4'h0, 4'h8, 4'hc};
		logic [3:0] exp [5] = '{4'h8, 4'h4, 4'h0, 4'h0, 4'h3};
		for (int i = 0; i < 5; i++) begin
			{ROLE_SELECT, LINE_PULLDOWN_ENABLE, DPLUS_PULLUP_ENABLE, DMINUS_PULLUP_ENABLE} = cfg[i];
			step(2);
			chk("pads", exp[i], pads);
		end
	endtask
	task t_host;
		IRQ_ENABLE = 16'hffff;
		plug = '1;
		step(8);
		chk("status", 16'h0201, IRQ_STATUS);
		chk("vbus", 16'h1, VBUS_LEVEL_FLAG);
		chk("line", 16'h1, LINE_STATE_FIELD);
		chk("outs", 16'h3, {COMBINED_IRQ_OUT, WAKEUP_IRQ_OUT});
		IRQ_CLEAR = 16'h0201;
		step(1);
		IRQ_CLEAR = '0;
		step(90);
		chk("outs", 16'h0, {COMBINED_IRQ_OUT, WAKEUP_IRQ_OUT});
		chk("attach", 16'h0, IRQ_STATUS[11]);
		OVERCURRENT_IN_B = '1;
		step(40);
		chk("attach", 16'h1, IRQ_STATUS[11]);
		chk("ovrcur", 16'h1, IRQ_STATUS[8]);
		for (int i = 1; i <= 3; i++) begin
			SETUP_FAIL_EV = '1;
			PIPE_TXN_FAIL = 10'h4;
			step(1);
			SETUP_FAIL_EV = '0;
			PIPE_TXN_FAIL = '0;
			chk("setup err", 16'(i == 3), IRQ_STATUS[14]);
			chk("not_ready_irq", (i == 3) ? 16'h4 : 16'h0, PIPE_NOTREADY_FLAG);
			step(1);
		end
		SETUP_ACK_EV = '1;
		PIPE_STALL_RX = 10'h20;
		step(1);
		SETUP_ACK_EV = '0;
		PIPE_STALL_RX = '0;
		chk("setup ok", 16'h1, IRQ_STATUS[13]);
		chk("not_ready_irq", 16'h24, PIPE_NOTREADY_FLAG);
		{DETACH_EV, FRAME_END_ERR_EV, PORTABLE_DETECT_EV} = '1;
		step(1);
		{DETACH_EV, FRAME_END_ERR_EV, PORTABLE_DETECT_EV} = '0;
		chk("host evs", 16'h9400, IRQ_STATUS & 16'h9400);
		plug = '0;
		step(8);
		chk("vbus", 16'h0, VBUS_LEVEL_FLAG);
	endtask
	task t_func;
		LINE_PULLDOWN_ENABLE = '0;
		step(1);
		ROLE_SELECT = '0;
		IRQ_ENABLE = '0;
		step(1);
		DPLUS_PULLUP_ENABLE = '1;
		NEW_DEV_STATE = 3'h5;
		BUS_RESET_EV = '1;
		step(1);
		BUS_RESET_EV = '0;
		chk("dvsq", 16'h5, DEV_STATE_FIELD);
		step(2);
		chk("comb", 16'h0, COMBINED_IRQ_OUT);
		IRQ_ENABLE = 16'h0008;
		step(2);
		chk("comb", 16'h1, COMBINED_IRQ_OUT);
		PIPE_SENT_EMPTY = 10'h8;
		PIPE_OVERSIZE = 10'h10;
		PIPE_NAK_BUF = 10'h2;
		PIPE_ISO_ERR = 10'h1;
		PIPE_ACCESSIBLE = 10'h80;
		{SOF_NEW_FRAME, CTRL_STAGE_EV, NEW_CTRL_STAGE} = 5'h1b;
		step(1);
		{PIPE_SENT_EMPTY, PIPE_OVERSIZE, PIPE_NAK_BUF, PIPE_ISO_ERR} = '0;
		{SOF_NEW_FRAME, CTRL_STAGE_EV} = '0;
		chk("ctsq", 16'h3, CTRL_STAGE_FIELD);
		step(1);
		chk("empty", 16'h18, PIPE_EMPTY_FLAG);
		chk("not_ready_irq", 16'h27, PIPE_NOTREADY_FLAG);
		chk("ready", 16'h80, PIPE_READY_FLAG);
		chk("irqs", 16'h3f, IRQ_STATUS[7:2]);
		plug = '1;
		SUSPENDED = '1;
		step(8);
		chk("resume", 16'h0, IRQ_STATUS[1]);
		resume_k = '1;
		step(6);
		chk("resume", 16'h1, IRQ_STATUS[1]);
	endtask
	initial begin
		step(4);
		RST = '0;
		t_run;
		t_pads;
		t_host;
		t_func;
		report_and_stop;
	end
	initial begin
		#40000;
		err_total++;
		report_and_stop;
	end
endmodule
